// ---- otgrs_pkg.sv ----
// otg role and session control: shared constants and types
package otgrs_pkg;

  // ----------------------------------------
  // register map (index on the plain port)
  // ----------------------------------------
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_MASK = 2'h2;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int unsigned BIT_ROLE = 7;
  localparam int unsigned BIT_FAST = 6;
  localparam int unsigned BIT_SLOW = 5;
  localparam int unsigned BIT_VBHI = 4;
  localparam int unsigned BIT_VBLO = 3;
  localparam int unsigned BIT_HOST = 2;
  localparam int unsigned BIT_REQ  = 1;
  localparam int unsigned BIT_SESS = 0;

  // vbus level codes
  localparam logic [1:0] VBUS_BELOW_END = 2'h0;
  localparam logic [1:0] VBUS_ABOVE_END = 2'h1;
  localparam logic [1:0] VBUS_ABOVE_AV  = 2'h2;
  localparam logic [1:0] VBUS_ABOVE_VV  = 2'h3;

  // ----------------------------------------
  // synchronised pin vector layout
  // ----------------------------------------
  localparam int unsigned IN_W      = 10;
  localparam int unsigned IN_ID_A   = 0;
  localparam int unsigned IN_SEND   = 1;
  localparam int unsigned IN_AVAL   = 2;
  localparam int unsigned IN_VVAL   = 3;
  localparam int unsigned IN_SUSP   = 4;
  localparam int unsigned IN_CONN   = 5;
  localparam int unsigned IN_LOWSPD = 6;
  localparam int unsigned IN_CHIRP  = 7;
  localparam int unsigned IN_BRST   = 8;
  localparam int unsigned IN_HDONE  = 9;
  // id pin idles as A out of reset, so the role bit reads 0 until filtered
  localparam logic [IN_W-1:0] IN_RESET = 10'h001;

  // ----------------------------------------
  // interrupt status bits
  // ----------------------------------------
  localparam int unsigned EV_SESS_ON  = 0;
  localparam int unsigned EV_SESS_OFF = 1;
  localparam int unsigned EV_CONN     = 2;
  localparam int unsigned EV_DISC     = 3;
  localparam int unsigned EV_HNP_DONE = 4;
  localparam int unsigned EV_SOFT_DIS = 5;

  typedef enum logic [1:0] {
    HNP_IDLE = 2'b00,
    HNP_WAIT = 2'b01,
    HNP_ACT  = 2'b10
  } otgrs_hnp_e;

endpackage

// ---- otgrs_top.sv ----
// otg role and session control register with its state logic
`timescale 1ns/1ps
// What this block does
// RULE_01: bit 7 reads 0 for A, 1 for B
// RULE_02: role flag only meaningful during a session
// RULE_03: bit 6 flags full or high speed peer
// RULE_04: high speed told by chirp during reset
// RULE_05: bit 5 flags low speed peer
// RULE_06: bits 4-3 give the vbus level code
// RULE_07: bit 2 reads 1 while acting host
// RULE_08: B request starts negotiation on suspend
// RULE_09: hardware clears request when negotiation ends
// RULE_10: A software sets or clears session bit
// RULE_11: B hardware sets and clears session bit
// RULE_12: software sets session to start session request
// RULE_13: clearing session in suspend soft disconnects
// RULE_14: read-only bits ignore writes, all reset zero
module otgrs_top
  import otgrs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       id_grounded,
  input  wire logic       vbus_above_send,
  input  wire logic       vbus_above_aval,
  input  wire logic       vbus_above_vval,
  input  wire logic       bus_suspended,
  input  wire logic       peer_connected,
  input  wire logic       peer_low_speed,
  input  wire logic       hs_chirp_seen,
  input  wire logic       bus_reset_active,
  input  wire logic       hnp_finished,
  output logic            host_active,
  output logic            session_drive,
  output logic            srp_start,
  output logic            hnp_start,
  output logic            soft_disconnect,
  output logic            peer_high_speed,
  output logic            irq
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // comparator outputs to level code; higher wins
  function automatic logic [1:0] vbus_code(
    input logic send,
    input logic aval,
    input logic vval
  );
    if (vval) begin
      return VBUS_ABOVE_VV;
    end else if (aval) begin
      return VBUS_ABOVE_AV;
    end else if (send) begin
      return VBUS_ABOVE_END;
    end
    return VBUS_BELOW_END;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [IN_W-1:0] sync1_ff;
  logic [IN_W-1:0] sync2_ff;
  logic [IN_W-1:0] sync3_ff;
  logic [IN_W-1:0] filt_ff;
  logic            b_role_ff;
  logic            sess_ff;
  logic            sess_q_ff;
  logic            vbus_on_q_ff;
  logic            host_ff;
  logic            req_ff;
  logic            fast_ff;
  logic            slow_ff;
  logic            hs_ff;
  logic            conn_q_ff;
  logic            done_q_ff;
  otgrs_hnp_e      hnp_ff;
  otgrs_hnp_e      nxt_hnp;
  logic [7:0]      stat_ff;
  logic [7:0]      nxt_stat;
  logic [7:0]      mask_ff;
  logic [7:0]      nxt_mask;
  logic [7:0]      ev;
  logic [7:0]      ctrl_view;
  logic [1:0]      vbus_lvl;
  logic            vbus_on;
  logic            susp;
  logic            peer_conn;
  logic            done_rise;
  logic            wr_ctrl;
  logic            rd_stat;
  logic            hnp_end;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // three stages; a bit moves only once stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= IN_RESET;
      sync2_ff <= IN_RESET;
      sync3_ff <= IN_RESET;
    end else begin
      sync1_ff <= {hnp_finished, bus_reset_active, hs_chirp_seen,
                   peer_low_speed, peer_connected, bus_suspended,
                   vbus_above_vval, vbus_above_aval, vbus_above_send,
                   id_grounded};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // filtered view, held while the two late stages disagree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      filt_ff <= IN_RESET; // RULE_14
    end else begin
      filt_ff <= (sync2_ff & ~(sync2_ff ^ sync3_ff)) |
                 (filt_ff & (sync2_ff ^ sync3_ff));
    end
  end

  // ----------------------------------------
  // decoded link conditions
  // ----------------------------------------
  assign vbus_lvl = vbus_code(filt_ff[IN_SEND], filt_ff[IN_AVAL],
                              filt_ff[IN_VVAL]); // RULE_06
  assign vbus_on   = (vbus_lvl != VBUS_BELOW_END);
  assign susp      = filt_ff[IN_SUSP];
  assign peer_conn = filt_ff[IN_CONN];
  assign done_rise = filt_ff[IN_HDONE] & ~done_q_ff;
  assign wr_ctrl   = reg_wr & (reg_addr == ADDR_CTRL);
  assign rd_stat   = reg_rd & (reg_addr == ADDR_STAT);
  assign hnp_end   = (hnp_ff == HNP_ACT) & done_rise;

  // edge history for events
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sess_q_ff    <= 1'b0;
      vbus_on_q_ff <= 1'b0;
      conn_q_ff    <= 1'b0;
      done_q_ff    <= 1'b0;
    end else begin
      sess_q_ff    <= sess_ff;
      vbus_on_q_ff <= vbus_on;
      conn_q_ff    <= fast_ff | slow_ff;
      done_q_ff    <= filt_ff[IN_HDONE];
    end
  end

  // ----------------------------------------
  // role
  // ----------------------------------------
  // frozen during a session so a glitching id pin cannot flip it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      b_role_ff <= 1'b0;
    end else if (!sess_ff) begin
      b_role_ff <= ~filt_ff[IN_ID_A]; // RULE_01 RULE_02
    end
  end

  // ----------------------------------------
  // session bit
  // ----------------------------------------
  // hardware threshold crossings win over a same-cycle write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sess_ff <= 1'b0;
    end else if (b_role_ff && vbus_on && !vbus_on_q_ff) begin
      sess_ff <= 1'b1; // RULE_11
    end else if (b_role_ff && !vbus_on && vbus_on_q_ff) begin
      sess_ff <= 1'b0; // RULE_11
    end else if (wr_ctrl && reg_wdata[BIT_SESS]) begin
      sess_ff <= 1'b1; // RULE_10 RULE_12
    end else if (wr_ctrl && (!b_role_ff || susp)) begin
      sess_ff <= 1'b0; // RULE_10 RULE_13
    end
  end

  // one-cycle requests toward the transceiver logic
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      srp_start       <= 1'b0;
      soft_disconnect <= 1'b0;
    end else begin
      srp_start <= wr_ctrl & reg_wdata[BIT_SESS] & b_role_ff
                   & ~sess_ff; // RULE_12
      soft_disconnect <= wr_ctrl & ~reg_wdata[BIT_SESS] & sess_ff
                         & susp; // RULE_13
    end
  end

  // ----------------------------------------
  // host role
  // ----------------------------------------
  // A side hosts its session; B side hosts only after negotiation
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      host_ff <= 1'b0;
    end else if (!sess_ff) begin
      host_ff <= 1'b0;
    end else if (!b_role_ff) begin
      host_ff <= 1'b1; // RULE_07
    end else if (hnp_end) begin
      host_ff <= 1'b1; // RULE_07
    end
  end

  // ----------------------------------------
  // host negotiation request
  // ----------------------------------------
  // a software set in the same cycle as the clear wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_ff <= 1'b0;
    end else if (wr_ctrl) begin
      req_ff <= reg_wdata[BIT_REQ];
    end else if (hnp_end) begin
      req_ff <= 1'b0; // RULE_09
    end
  end

  // negotiation sequencer
  always_comb begin
    nxt_hnp = hnp_ff;
    case (hnp_ff)
      HNP_IDLE: begin
        if (b_role_ff && req_ff && sess_ff) begin
          nxt_hnp = HNP_WAIT;
        end
      end
      HNP_WAIT: begin
        if (!req_ff || !sess_ff) begin
          nxt_hnp = HNP_IDLE;
        end else if (susp) begin
          nxt_hnp = HNP_ACT; // RULE_08
        end
      end
      HNP_ACT: begin
        if (done_rise || !sess_ff) begin
          nxt_hnp = HNP_IDLE; // RULE_09
        end
      end
      default: begin
        nxt_hnp = HNP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hnp_ff    <= HNP_IDLE;
      hnp_start <= 1'b0;
    end else begin
      hnp_ff    <= nxt_hnp;
      hnp_start <= (hnp_ff == HNP_WAIT) & (nxt_hnp == HNP_ACT); // RULE_08
    end
  end

  // ----------------------------------------
  // peer speed detection
  // ----------------------------------------
  // only tracked as host; cleared on detach so stale speed never shows
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fast_ff <= 1'b0;
      slow_ff <= 1'b0;
      hs_ff   <= 1'b0;
    end else if (!host_ff || !peer_conn) begin
      fast_ff <= 1'b0;
      slow_ff <= 1'b0;
      hs_ff   <= 1'b0;
    end else begin
      fast_ff <= ~filt_ff[IN_LOWSPD]; // RULE_03
      slow_ff <= filt_ff[IN_LOWSPD];  // RULE_05
      if (filt_ff[IN_BRST] && filt_ff[IN_CHIRP] && !filt_ff[IN_LOWSPD]) begin
        hs_ff <= 1'b1; // RULE_04
      end
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  always_comb begin
    ev              = '0;
    ev[EV_SESS_ON]  = sess_ff & ~sess_q_ff;
    ev[EV_SESS_OFF] = ~sess_ff & sess_q_ff;
    ev[EV_CONN]     = (fast_ff | slow_ff) & ~conn_q_ff;
    ev[EV_DISC]     = ~(fast_ff | slow_ff) & conn_q_ff;
    ev[EV_HNP_DONE] = hnp_end;
    ev[EV_SOFT_DIS] = soft_disconnect;
  end

  // read clears; an event in the clearing cycle survives
  assign nxt_stat = (stat_ff & ~{8{rd_stat}}) | ev;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_ff <= REG_RESET;
      irq     <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq     <= |(nxt_stat & nxt_mask);
    end
  end

  // irq uses the next mask so it never lags a mask write by a cycle
  assign nxt_mask = (reg_wr && reg_addr == ADDR_MASK) ? reg_wdata : mask_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_ff <= REG_RESET;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  // only bits 1 and 0 are writable; the rest are live status
  assign ctrl_view = {b_role_ff, fast_ff, slow_ff, vbus_lvl,
                      host_ff, req_ff, sess_ff}; // RULE_14

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= REG_RESET;
    end else if (!reg_rd) begin
      reg_rdata <= REG_RESET;
    end else begin
      case (reg_addr)
        ADDR_CTRL: reg_rdata <= ctrl_view;
        ADDR_STAT: reg_rdata <= stat_ff;
        ADDR_MASK: reg_rdata <= mask_ff;
        default:   reg_rdata <= REG_RESET;
      endcase
    end
  end

  // mirrored levels, registered so outputs come from flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      host_active     <= 1'b0;
      session_drive   <= 1'b0;
      peer_high_speed <= 1'b0;
    end else begin
      host_active     <= host_ff;
      session_drive   <= sess_ff;
      peer_high_speed <= hs_ff;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_role_read: assert property ( // RULE_01
    reg_rd && reg_addr == ADDR_CTRL |=> reg_rdata[BIT_ROLE] == $past(b_role_ff))
    else $error("role bit read wrong");

  a_role_frozen: assert property ( // RULE_02
    sess_ff && $past(sess_ff) |-> $stable(b_role_ff))
    else $error("role changed in session");

  a_fast_host: assert property ( // RULE_03
    fast_ff |-> $past(host_ff) && $past(peer_conn))
    else $error("fast peer flag outside host");

  a_hs_chirp: assert property ( // RULE_04
    $rose(hs_ff) |-> $past(filt_ff[IN_BRST] && filt_ff[IN_CHIRP]))
    else $error("high speed without chirp");

  a_slow_excl: assert property ( // RULE_05
    slow_ff |-> !fast_ff && $past(filt_ff[IN_LOWSPD]))
    else $error("slow peer flag wrong");

  a_vbus_read: assert property ( // RULE_06
    reg_rd && reg_addr == ADDR_CTRL |=> reg_rdata[4:3] == $past(vbus_lvl))
    else $error("vbus code read wrong");

  a_host_sess: assert property ( // RULE_07
    host_ff |-> $past(sess_ff) ##1 host_active)
    else $error("host without session");

  a_hnp_start: assert property ( // RULE_08
    hnp_start |-> $past(req_ff && susp && b_role_ff && hnp_ff == HNP_WAIT))
    else $error("negotiation start without cause");

  a_req_clear: assert property ( // RULE_09
    hnp_end && !wr_ctrl |=> !req_ff)
    else $error("request not cleared");

  a_b_sess_on: assert property ( // RULE_11
    b_role_ff && vbus_on && !vbus_on_q_ff |=> sess_ff ##1 session_drive)
    else $error("B session not started");

  a_soft_disc: assert property ( // RULE_13
    soft_disconnect |-> !sess_ff && $past(susp))
    else $error("soft disconnect wrong");

  a_irq_level: assert property (
    irq == |(stat_ff & mask_ff))
    else $error("irq not raised");

  c_a_session: cover property (!b_role_ff && $rose(sess_ff));
  c_hnp_run: cover property (hnp_start ##[1:50] hnp_end);
  c_hs_peer: cover property ($rose(hs_ff));
  c_soft_disc: cover property (soft_disconnect);

endmodule

// ---- otgrs_peer.sv ----
// cable peer model: id pin, vbus comparators, line state and negotiation answer
`timescale 1ns/1ps
module otgrs_peer (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       we_are_a,
  input  wire logic [1:0] vbus_lvl,
  input  wire logic       attach,
  input  wire logic       low_spd,
  input  wire logic       suspend,
  input  wire logic       reset_bus,
  input  wire logic       slow_ans,
  input  wire logic       hnp_start,
  output logic            id_grounded,
  output logic            vbus_above_send,
  output logic            vbus_above_aval,
  output logic            vbus_above_vval,
  output logic            bus_suspended,
  output logic            peer_connected,
  output logic            peer_low_speed,
  output logic            hs_chirp_seen,
  output logic            bus_reset_active,
  output logic            hnp_finished
);
  logic [3:0] hnp_cnt_ff;
  logic [3:0] hnp_done_at;

  // ----------------------------------------
  // cable levels
  // ----------------------------------------
  // comparators are nested thresholds, so the code is thermometer-like
  assign id_grounded      = we_are_a;
  assign vbus_above_send  = (vbus_lvl != 2'h0);
  assign vbus_above_aval  = vbus_lvl[1];
  assign vbus_above_vval  = (vbus_lvl == 2'h3);
  assign bus_suspended    = suspend;
  assign peer_connected   = attach;
  assign peer_low_speed   = attach & low_spd;
  assign bus_reset_active = reset_bus;
  // only a high speed peer chirps, and only while it is being reset
  assign hs_chirp_seen    = reset_bus & attach & ~low_spd;

  // ----------------------------------------
  // negotiation answer
  // ----------------------------------------
  // prompt or slow turnaround; finished falls once suspend is left
  assign hnp_done_at = slow_ans ? 4'hf : 4'h2;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hnp_cnt_ff <= 4'h0;
    end else if (hnp_start) begin
      hnp_cnt_ff <= 4'h1;
    end else if (!suspend) begin
      hnp_cnt_ff <= 4'h0;
    end else if (hnp_cnt_ff != 4'h0 && hnp_cnt_ff != hnp_done_at) begin
      hnp_cnt_ff <= hnp_cnt_ff + 4'h1;
    end
  end
  assign hnp_finished = (hnp_cnt_ff == hnp_done_at) && (hnp_cnt_ff != 4'h0);
endmodule

// ---- testbench.sv ----
// self-checking bench for the otg role and session control block
`timescale 1ns/1ps
module testbench;
  import otgrs_pkg::*;
  logic       clk;
  logic       reset_n;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       id_grounded, vbus_above_send, vbus_above_aval, vbus_above_vval;
  logic       bus_suspended, peer_connected, peer_low_speed, hs_chirp_seen;
  logic       bus_reset_active, hnp_finished;
  logic       host_active, session_drive, srp_start, hnp_start;
  logic       soft_disconnect, peer_high_speed, irq;
  logic       we_are_a, attach, low_spd, suspend, reset_bus, slow_ans;
  logic [1:0] vbus_lvl;
  int         mismatches;
  int         num_checks;
  int         n_srp, n_hnp, n_soft;
  logic [7:0] d;

  // ----------------------------------------
  // clock, instances, pulse counters
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  otgrs_top otgrs_top_inst (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .id_grounded(id_grounded), .vbus_above_send(vbus_above_send),
    .vbus_above_aval(vbus_above_aval), .vbus_above_vval(vbus_above_vval),
    .bus_suspended(bus_suspended), .peer_connected(peer_connected),
    .peer_low_speed(peer_low_speed), .hs_chirp_seen(hs_chirp_seen),
    .bus_reset_active(bus_reset_active), .hnp_finished(hnp_finished),
    .host_active(host_active), .session_drive(session_drive), .srp_start(srp_start),
    .hnp_start(hnp_start), .soft_disconnect(soft_disconnect),
    .peer_high_speed(peer_high_speed), .irq(irq));

  otgrs_peer otgrs_peer_inst (.clk(clk), .reset_n(reset_n), .we_are_a(we_are_a),
    .vbus_lvl(vbus_lvl), .attach(attach), .low_spd(low_spd), .suspend(suspend),
    .reset_bus(reset_bus), .slow_ans(slow_ans), .hnp_start(hnp_start),
    .id_grounded(id_grounded), .vbus_above_send(vbus_above_send),
    .vbus_above_aval(vbus_above_aval), .vbus_above_vval(vbus_above_vval),
    .bus_suspended(bus_suspended), .peer_connected(peer_connected),
    .peer_low_speed(peer_low_speed), .hs_chirp_seen(hs_chirp_seen),
    .bus_reset_active(bus_reset_active), .hnp_finished(hnp_finished));

  // one-cycle pulses are counted so no scenario can miss them
  always @(posedge clk) begin
    if (srp_start === 1'b1) n_srp++;
    if (hnp_start === 1'b1) n_hnp++;
    if (soft_disconnect === 1'b1) n_soft++;
  end

  // ----------------------------------------
  // bus cycles and comparison
  // ----------------------------------------
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe; taken at its end
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // pins pass a filter: give them time to land
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  task automatic ctrl_is(input logic [7:0] exp);
    rd(ADDR_CTRL, d);
    chk("ctrl", exp, d);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_map();
    rd(ADDR_CTRL, d);
    chk("ctrl reset", REG_RESET, d);
    rd(ADDR_MASK, d);
    chk("mask reset", REG_RESET, d);
    wr(2'h3, 8'hff);
    rd(2'h3, d);
    chk("unmapped", 8'h00, d);
    wr(ADDR_STAT, 8'hff);
    rd(ADDR_STAT, d);
    chk("status ro", 8'h00, d);
  endtask

  task automatic t_vbus_codes();
    for (int l = 0; l < 4; l++) begin
      vbus_lvl <= l[1:0];
      settle();
      ctrl_is({3'b000, l[1:0], 3'b000});
    end
  endtask

  task automatic t_a_host();
    wr(ADDR_MASK, 8'h04);
    wr(ADDR_CTRL, 8'hfd);
    settle();
    ctrl_is(8'h1d);
    chk("sess drive", 8'h01, {7'h0, session_drive});
    chk("host out", 8'h01, {7'h0, host_active});
    attach <= 1'b1;
    settle();
    ctrl_is(8'h5d);
    chk("irq set", 8'h01, {7'h0, irq});
    rd(ADDR_STAT, d);
    chk("status", 8'h05, d);
    @(posedge clk);
    chk("irq clr", 8'h00, {7'h0, irq});
    reset_bus <= 1'b1;
    settle();
    reset_bus <= 1'b0;
    settle();
    chk("high speed", 8'h01, {7'h0, peer_high_speed});
    low_spd <= 1'b1;
    settle();
    ctrl_is(8'h3d);
    attach <= 1'b0;
    low_spd <= 1'b0;
    wr(ADDR_CTRL, 8'h00);
    settle();
    ctrl_is(8'h18);
    chk("irq masked", 8'h00, {7'h0, irq});
    rd(ADDR_STAT, d);
    chk("status off", 8'h0a, d);
  endtask

  task automatic t_b_session();
    we_are_a <= 1'b0;
    vbus_lvl <= 2'h0;
    settle();
    ctrl_is(8'h80);
    vbus_lvl <= 2'h3;
    settle();
    ctrl_is(8'h99);
    vbus_lvl <= 2'h0;
    settle();
    ctrl_is(8'h80);
    wr(ADDR_CTRL, 8'h01);
    settle();
    chk("srp pulse", 8'h01, n_srp[7:0]);
    ctrl_is(8'h81);
  endtask

  task automatic t_b_negotiate();
    vbus_lvl <= 2'h3;
    settle();
    wr(ADDR_CTRL, 8'h03);
    settle();
    ctrl_is(8'h9b);
    chk("no early hnp", 8'h00, n_hnp[7:0]);
    suspend <= 1'b1;
    repeat (30) @(posedge clk);
    chk("hnp pulse", 8'h01, n_hnp[7:0]);
    ctrl_is(8'h9d);
    wr(ADDR_CTRL, 8'h00);
    settle();
    chk("soft disc", 8'h01, n_soft[7:0]);
    ctrl_is(8'h98);
    rd(ADDR_STAT, d);
    chk("status hnp", 8'h33, d);
  endtask

  // ----------------------------------------
  // verdict and main sequence
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #100us;
    mismatches++;
    end_of_test();
  end

  initial begin
    mismatches = 0;
    num_checks = 0;
    n_srp = 0;
    n_hnp = 0;
    n_soft = 0;
    reset_n = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    we_are_a = 1'b1;
    vbus_lvl = 2'h0;
    attach = 1'b0;
    low_spd = 1'b0;
    suspend = 1'b0;
    reset_bus = 1'b0;
    slow_ans = 1'b1;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_reset_map();
    t_vbus_codes();
    t_a_host();
    t_b_session();
    t_b_negotiate();
    end_of_test();
  end
endmodule
